// ### rtl/bsu_pkg.sv
// Purpose: Constants, opcodes and types for the branch, skip and bit-operation unit.
// Assumes: One core clock, synchronous active-low reset, 8-bit data path.
// Notes:  Flag positions follow the usual status byte order, carry in bit 0.
// Behaviour
// - Skip next when selected register bit set
// - Skip next on I/O bit clear/set
// - Indexed flag branch, target PC+k+1
// - Equal/not-equal branches test zero flag
// - Carry branches and unsigned aliases share tests
// - Minus/plus branches test negative flag
// - Signed branches test negative xor overflow
// - Half-carry branches test half-carry flag
// - Transfer-flag branches test transfer flag
// - Overflow branches test overflow flag
// - Interrupt-state branches; branches keep all flags
// - Set/clear one I/O bit, two clocks
// - Rotates through carry update Z C N V
// - Arithmetic right shift keeps sign bit
// - Bit store copies register bit to transfer
// - Bit load writes transfer flag to register
package bsu_pkg;

  // Data path widths
  localparam int DATA_W = 8;
  localparam int OFS_W = 7;
  localparam int OP_W = 6;

  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Execution lengths in clocks
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Program counter steps
  localparam int PC_STEP_REL = 1;
  localparam int PC_SKIP_ONE = 2;
  localparam int PC_SKIP_TWO = 3;

  // Instruction codes
  typedef enum logic [5:0] {
    OP_SKIP_IF_REG_BIT_SET          = 6'h00,
    OP_SKIP_IF_IO_BIT_CLEAR         = 6'h01,
    OP_SKIP_IF_IO_BIT_SET           = 6'h02,
    OP_BRANCH_IF_FLAG_SET           = 6'h03,
    OP_BRANCH_IF_FLAG_CLEAR         = 6'h04,
    OP_BRANCH_IF_EQUAL              = 6'h05,
    OP_BRANCH_IF_NOT_EQUAL          = 6'h06,
    OP_BRANCH_IF_CARRY_SET          = 6'h07,
    OP_BRANCH_IF_CARRY_CLEAR        = 6'h08,
    OP_BRANCH_IF_SAME_OR_HIGHER     = 6'h09,
    OP_BRANCH_IF_LOWER              = 6'h0a,
    OP_BRANCH_IF_MINUS              = 6'h0b,
    OP_BRANCH_IF_PLUS               = 6'h0c,
    OP_BRANCH_IF_SIGNED_GE          = 6'h0d,
    OP_BRANCH_IF_SIGNED_LESS        = 6'h0e,
    OP_BRANCH_IF_HALF_CARRY_SET     = 6'h0f,
    OP_BRANCH_IF_HALF_CARRY_CLEAR   = 6'h10,
    OP_BRANCH_IF_TRANSFER_FLAG_SET  = 6'h11,
    OP_BRANCH_IF_TRANSFER_FLAG_CLEAR = 6'h12,
    OP_BRANCH_IF_OVERFLOW_SET       = 6'h13,
    OP_BRANCH_IF_OVERFLOW_CLEAR     = 6'h14,
    OP_BRANCH_IF_IRQ_ENABLED        = 6'h15,
    OP_BRANCH_IF_IRQ_DISABLED       = 6'h16,
    OP_SET_IO_BIT                   = 6'h17,
    OP_CLEAR_IO_BIT                 = 6'h18,
    OP_LOGICAL_SHIFT_LEFT           = 6'h19,
    OP_LOGICAL_SHIFT_RIGHT          = 6'h1a,
    OP_ROTATE_LEFT_THROUGH_CARRY    = 6'h1b,
    OP_ROTATE_RIGHT_THROUGH_CARRY   = 6'h1c,
    OP_ARITH_SHIFT_RIGHT            = 6'h1d,
    OP_SET_STATUS_FLAG_BIT          = 6'h1e,
    OP_CLEAR_STATUS_FLAG_BIT        = 6'h1f,
    OP_STORE_BIT_TO_TRANSFER_FLAG   = 6'h20,
    OP_LOAD_BIT_FROM_TRANSFER_FLAG  = 6'h21,
    OP_SET_CARRY_FLAG               = 6'h22,
    OP_CLEAR_CARRY_FLAG             = 6'h23,
    OP_SET_NEGATIVE_FLAG            = 6'h24
  } bsu_op_e;

  // Shifter operations
  typedef enum logic [2:0] {
    SH_NONE = 3'h0,
    SH_LOG_LEFT = 3'h1,
    SH_LOG_RIGHT = 3'h2,
    SH_ROT_LEFT = 3'h3,
    SH_ROT_RIGHT = 3'h4,
    SH_ARITH_RIGHT = 3'h5
  } bsu_shift_e;

  // Control states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } bsu_state_e;

endpackage

// ### rtl/bsu_shift_if.sv
// Purpose: Carries one shift request and its result between core and shifter.
// Assumes: Purely combinational use within one clock.
// Notes:  The core drives the request side, the shifter the result side.
interface bsu_shift_if;
  import bsu_pkg::*;
  bsu_shift_e op;
  logic [DATA_W-1:0] din;
  logic cin;
  logic [DATA_W-1:0] dout;
  logic cout;
  logic zero;
  logic neg;
  logic ovf;
  modport core (output op, output din, output cin,
                input dout, input cout, input zero, input neg, input ovf);
  modport unit (input op, input din, input cin,
                output dout, output cout, output zero, output neg, output ovf);
endinterface

// ### rtl/bsu_shift.sv
// Purpose: Shift and rotate data path with flag results.
// Assumes: Operand and carry in are stable for the cycle.
// Notes:  Overflow is negative xor carry after the shift.
module bsu_shift
  import bsu_pkg::*;
(
  // Request and result
  bsu_shift_if.unit sh
);

  logic [DATA_W-1:0] res;
  logic co;

  // Shift network
  always_comb begin
    res = sh.din;
    co = 1'b0;
    case (sh.op)
      SH_LOG_LEFT: begin
        res = {sh.din[DATA_W-2:0], 1'b0};
        co = sh.din[DATA_W-1];
      end
      SH_LOG_RIGHT: begin
        res = {1'b0, sh.din[DATA_W-1:1]};
        co = sh.din[0];
      end
      SH_ROT_LEFT: begin
        res = {sh.din[DATA_W-2:0], sh.cin};
        co = sh.din[DATA_W-1];
      end
      SH_ROT_RIGHT: begin
        res = {sh.cin, sh.din[DATA_W-1:1]};
        co = sh.din[0];
      end
      SH_ARITH_RIGHT: begin
        res = {sh.din[DATA_W-1], sh.din[DATA_W-1:1]};
        co = sh.din[0];
      end
      default: begin
        res = sh.din;
        co = sh.cin;
      end
    endcase
  end

  // Result and flags
  assign sh.dout = res;
  assign sh.cout = co;
  assign sh.zero = (res == '0);
  assign sh.neg = res[DATA_W-1];
  assign sh.ovf = res[DATA_W-1] ^ co;

endmodule

// ### rtl/bsu_top.sv
// Purpose: Executes skips, flag branches, I/O bit writes, shifts and flag bit moves.
// Assumes: Operands are valid in the cycle START is high and READY is high.
// Notes:  Results and strobes appear together with DONE, held status inside.
module bsu_top
  import bsu_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Instruction issue
  input wire logic START,
  input wire logic [OP_W-1:0] OP,
  input wire logic [2:0] BIT_SEL,
  input wire logic [OFS_W-1:0] OFFSET,
  input wire logic [PC_W-1:0] PC_IN,
  input wire logic NEXT_TWO_WORD,
  // Operand reads
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic [DATA_W-1:0] IO_RDATA,
  // Handshake
  output logic READY,
  output logic DONE,
  // Program counter
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_NEXT,
  // Register and I/O writes
  output logic REG_WE,
  output logic [DATA_W-1:0] REG_WDATA,
  output logic IO_WE,
  output logic [DATA_W-1:0] IO_WDATA,
  // Status byte
  output logic [DATA_W-1:0] STATUS_FLAGS
);

  bsu_state_e state_ff, nxt_state;
  logic [1:0] cnt_ff;
  logic ready_ff, done_ff, pc_load_ff, reg_we_ff, io_we_ff;
  logic [PC_W-1:0] pc_next_ff;
  logic [DATA_W-1:0] reg_wdata_ff, io_wdata_ff;
  logic [DATA_W-1:0] status_flags_ff, nxt_flags, pend_flags_ff;
  logic pend_pc_ff, pend_reg_ff, pend_io_ff, pend_flag_ff;

  // Decode results
  bsu_op_e op;
  logic accept, finish;
  logic cond, is_branch, is_skip, wr_reg, wr_io, wr_flag;
  logic [1:0] cycles;
  logic [PC_W-1:0] target;
  logic [DATA_W-1:0] reg_res, io_res;
  logic sel_reg_bit, sel_io_bit, sel_flag_bit;
  logic [PC_W-1:0] rel_target, skip_target;

  bsu_shift_if sh ();

  bsu_shift u_shift (
    .sh(sh)
  );

  assign op = bsu_op_e'(OP);
  assign accept = START & ready_ff;
  assign finish = (state_ff == ST_WAIT) && (cnt_ff == CYC_ONE);

  // Operand bit selects
  assign sel_reg_bit = REG_RDATA[BIT_SEL];
  assign sel_io_bit = IO_RDATA[BIT_SEL];
  assign sel_flag_bit = status_flags_ff[BIT_SEL];

  // Relative and skip targets
  assign rel_target = PC_IN + {{(PC_W-OFS_W){OFFSET[OFS_W-1]}}, OFFSET}
                      + PC_W'(PC_STEP_REL);
  assign skip_target = NEXT_TWO_WORD ? PC_IN + PC_W'(PC_SKIP_TWO)
                                     : PC_IN + PC_W'(PC_SKIP_ONE);

  // Shifter request
  always_comb begin
    sh.din = REG_RDATA;
    sh.cin = status_flags_ff[FLAG_C];
    case (op)
      OP_LOGICAL_SHIFT_LEFT: sh.op = SH_LOG_LEFT;
      OP_LOGICAL_SHIFT_RIGHT: sh.op = SH_LOG_RIGHT;
      OP_ROTATE_LEFT_THROUGH_CARRY: sh.op = SH_ROT_LEFT;
      OP_ROTATE_RIGHT_THROUGH_CARRY: sh.op = SH_ROT_RIGHT;
      OP_ARITH_SHIFT_RIGHT: sh.op = SH_ARITH_RIGHT;
      default: sh.op = SH_NONE;
    endcase
  end

  // Condition, length and results of the offered instruction
  always_comb begin
    cond = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    wr_reg = 1'b0;
    wr_io = 1'b0;
    wr_flag = 1'b0;
    reg_res = REG_RDATA;
    io_res = IO_RDATA;
    nxt_flags = status_flags_ff;
    case (op)
      OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        cond = sel_reg_bit;
      end
      OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond = ~sel_io_bit;
      end
      OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        cond = sel_io_bit;
      end
      OP_BRANCH_IF_FLAG_SET: begin
        is_branch = 1'b1;
        cond = sel_flag_bit;
      end
      OP_BRANCH_IF_FLAG_CLEAR: begin
        is_branch = 1'b1;
        cond = ~sel_flag_bit;
      end
      OP_BRANCH_IF_EQUAL: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_Z];
      end
      OP_BRANCH_IF_NOT_EQUAL: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_Z];
      end
      OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_C];
      end
      OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_C];
      end
      OP_BRANCH_IF_MINUS: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_N];
      end
      OP_BRANCH_IF_PLUS: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_N];
      end
      OP_BRANCH_IF_SIGNED_GE: begin
        is_branch = 1'b1;
        cond = ~(status_flags_ff[FLAG_N] ^ status_flags_ff[FLAG_V]);
      end
      OP_BRANCH_IF_SIGNED_LESS: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_N] ^ status_flags_ff[FLAG_V];
      end
      OP_BRANCH_IF_HALF_CARRY_SET: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_H];
      end
      OP_BRANCH_IF_HALF_CARRY_CLEAR: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_H];
      end
      OP_BRANCH_IF_TRANSFER_FLAG_SET: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_T];
      end
      OP_BRANCH_IF_TRANSFER_FLAG_CLEAR: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_T];
      end
      OP_BRANCH_IF_OVERFLOW_SET: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_V];
      end
      OP_BRANCH_IF_OVERFLOW_CLEAR: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_V];
      end
      OP_BRANCH_IF_IRQ_ENABLED: begin
        is_branch = 1'b1;
        cond = status_flags_ff[FLAG_I];
      end
      OP_BRANCH_IF_IRQ_DISABLED: begin
        is_branch = 1'b1;
        cond = ~status_flags_ff[FLAG_I];
      end
      OP_SET_IO_BIT: begin
        wr_io = 1'b1;
        io_res[BIT_SEL] = 1'b1;
      end
      OP_CLEAR_IO_BIT: begin
        wr_io = 1'b1;
        io_res[BIT_SEL] = 1'b0;
      end
      OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_LEFT_THROUGH_CARRY,
      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ARITH_SHIFT_RIGHT: begin
        wr_reg = 1'b1;
        wr_flag = 1'b1;
        reg_res = sh.dout;
        nxt_flags[FLAG_Z] = sh.zero;
        nxt_flags[FLAG_C] = sh.cout;
        nxt_flags[FLAG_N] = sh.neg;
        nxt_flags[FLAG_V] = sh.ovf;
      end
      OP_SET_STATUS_FLAG_BIT: begin
        wr_flag = 1'b1;
        nxt_flags[BIT_SEL] = 1'b1;
      end
      OP_CLEAR_STATUS_FLAG_BIT: begin
        wr_flag = 1'b1;
        nxt_flags[BIT_SEL] = 1'b0;
      end
      OP_STORE_BIT_TO_TRANSFER_FLAG: begin
        wr_flag = 1'b1;
        nxt_flags[FLAG_T] = sel_reg_bit;
      end
      OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
        wr_reg = 1'b1;
        reg_res[BIT_SEL] = status_flags_ff[FLAG_T];
      end
      OP_SET_CARRY_FLAG: begin
        wr_flag = 1'b1;
        nxt_flags[FLAG_C] = 1'b1;
      end
      OP_CLEAR_CARRY_FLAG: begin
        wr_flag = 1'b1;
        nxt_flags[FLAG_C] = 1'b0;
      end
      OP_SET_NEGATIVE_FLAG: begin
        wr_flag = 1'b1;
        nxt_flags[FLAG_N] = 1'b1;
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // Clock count and program counter target
  always_comb begin
    cycles = CYC_ONE;
    target = PC_IN;
    if (is_skip && cond) begin
      cycles = NEXT_TWO_WORD ? CYC_THREE : CYC_TWO;
      target = skip_target;
    end else if (is_branch && cond) begin
      cycles = CYC_TWO;
      target = rel_target;
    end else if (wr_io) begin
      cycles = CYC_TWO;
    end
  end

  // Control state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (accept && (cycles != CYC_ONE)) nxt_state = ST_WAIT;
      ST_WAIT: if (finish) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State, counter and handshake
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CYC_ONE;
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (accept) begin
        cnt_ff <= cycles - CYC_ONE;
      end else if (state_ff == ST_WAIT) begin
        cnt_ff <= cnt_ff - CYC_ONE;
      end
      ready_ff <= (nxt_state == ST_IDLE);
      done_ff <= (accept && (cycles == CYC_ONE)) || finish;
    end
  end

  // Pending strobes of a multi-clock instruction
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pend_pc_ff <= 1'b0;
      pend_reg_ff <= 1'b0;
      pend_io_ff <= 1'b0;
      pend_flag_ff <= 1'b0;
      pend_flags_ff <= FLAGS_RESET;
    end else if (accept) begin
      pend_pc_ff <= cond & (is_branch | is_skip);
      pend_reg_ff <= wr_reg;
      pend_io_ff <= wr_io;
      pend_flag_ff <= wr_flag;
      pend_flags_ff <= nxt_flags;
    end
  end

  // Output data, latched when the instruction is taken
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pc_next_ff <= '0;
      reg_wdata_ff <= '0;
      io_wdata_ff <= '0;
    end else if (accept) begin
      pc_next_ff <= target;
      reg_wdata_ff <= reg_res;
      io_wdata_ff <= io_res;
    end
  end

  // Write strobes, one cycle with DONE
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pc_load_ff <= 1'b0;
      reg_we_ff <= 1'b0;
      io_we_ff <= 1'b0;
    end else if (accept && (cycles == CYC_ONE)) begin
      pc_load_ff <= 1'b0;
      reg_we_ff <= wr_reg;
      io_we_ff <= 1'b0;
    end else if (finish) begin
      pc_load_ff <= pend_pc_ff;
      reg_we_ff <= pend_reg_ff;
      io_we_ff <= pend_io_ff;
    end else begin
      pc_load_ff <= 1'b0;
      reg_we_ff <= 1'b0;
      io_we_ff <= 1'b0;
    end
  end

  // Status byte; branches and skips never write it
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      status_flags_ff <= FLAGS_RESET;
    end else if (accept && (cycles == CYC_ONE) && wr_flag) begin
      status_flags_ff <= nxt_flags;
    end else if (finish && pend_flag_ff) begin
      status_flags_ff <= pend_flags_ff;
    end
  end

  assign READY = ready_ff;
  assign DONE = done_ff;
  assign PC_LOAD = pc_load_ff;
  assign PC_NEXT = pc_next_ff;
  assign REG_WE = reg_we_ff;
  assign REG_WDATA = reg_wdata_ff;
  assign IO_WE = io_we_ff;
  assign IO_WDATA = io_wdata_ff;
  assign STATUS_FLAGS = status_flags_ff;

  // Checks of timing and results
  sequence s_take_branch;
    accept && is_branch && cond;
  endsequence

  sequence s_take_skip_long;
    accept && is_skip && cond && NEXT_TWO_WORD;
  endsequence

  sequence s_two_clock_end;
    !DONE ##1 DONE;
  endsequence

  a_branch_two_clocks: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take_branch |=> s_two_clock_end ##0 PC_LOAD)
    else $error("taken branch did not finish in two clocks");

  a_branch_target_pc: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take_branch |-> ##2 (PC_NEXT == $past(rel_target, 2)))
    else $error("branch target is not pc plus offset plus one");

  a_branch_not_taken: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && is_branch && !cond) |=> DONE && !PC_LOAD)
    else $error("untaken branch not done in one clock");

  a_branch_flags_kept: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && (is_branch || is_skip)) |=> $stable(STATUS_FLAGS) ##1
      ($past(DONE) || $stable(STATUS_FLAGS)))
    else $error("branch or skip changed the status byte");

  a_skip_three_clocks: assert property (@(posedge CLK) disable iff (!RSTN)
    s_take_skip_long |=> !DONE ##1 s_two_clock_end ##0 (PC_LOAD &&
      PC_NEXT == $past(PC_IN, 3) + PC_W'(PC_SKIP_TWO)))
    else $error("skip over two words is wrong");

  a_skip_reg_bit: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_SKIP_IF_REG_BIT_SET && !NEXT_TWO_WORD) |->
      if (sel_reg_bit) (##2 (DONE && PC_LOAD)) else (##1 (DONE && !PC_LOAD)))
    else $error("register bit skip decision wrong");

  a_io_bit_write: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_SET_IO_BIT) |-> ##2 (IO_WE && DONE &&
      IO_WDATA == ($past(IO_RDATA, 2) | (8'h01 << $past(BIT_SEL, 2)))))
    else $error("set io bit write wrong");

  a_rotate_right_carry: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_ROTATE_RIGHT_THROUGH_CARRY) |=>
      (STATUS_FLAGS[FLAG_C] == $past(REG_RDATA[0])) &&
      (REG_WDATA[DATA_W-1] == $past(status_flags_ff[FLAG_C])) && REG_WE)
    else $error("rotate right carry path wrong");

  a_bit_store_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_STORE_BIT_TO_TRANSFER_FLAG) |=>
      DONE && (STATUS_FLAGS[FLAG_T] == $past(sel_reg_bit)) && !REG_WE)
    else $error("bit store did not reach transfer flag");

  a_bit_load_reg: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_LOAD_BIT_FROM_TRANSFER_FLAG) |=>
      REG_WE && $stable(STATUS_FLAGS) &&
      (REG_WDATA[$past(BIT_SEL)] == $past(status_flags_ff[FLAG_T])))
    else $error("bit load wrong");

  a_arith_sign_kept: assert property (@(posedge CLK) disable iff (!RSTN)
    (accept && op == OP_ARITH_SHIFT_RIGHT) |=>
      REG_WDATA[DATA_W-1] == $past(REG_RDATA[DATA_W-1]))
    else $error("arithmetic shift lost sign");

endmodule

// ### verification/test_bsu_top.sv
// Purpose: Self-checking bench for the branch, skip and bit-operation unit.
// Assumes: All inputs change by NBA at the rising clock edge.
// Notes: Expected values come from a flag model kept in the bench.
module test_bsu_top
  import bsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals
  logic clk, rstn, start, tw, ready, done, pc_load, reg_we, io_we;
  logic [OP_W-1:0] op;
  logic [2:0] bsel;
  logic [OFS_W-1:0] ofs;
  logic [15:0] pc, pc_next;
  logic [7:0] rdat, iodat, reg_wdata, io_wdata, flags, flg;
  int cyc, err_total, checked;

  // Unit under test
  bsu_top i_bsu_top (.CLK(clk), .RSTN(rstn), .START(start), .OP(op), .BIT_SEL(bsel),
    .OFFSET(ofs), .PC_IN(pc), .NEXT_TWO_WORD(tw), .REG_RDATA(rdat), .IO_RDATA(iodat),
    .READY(ready), .DONE(done), .PC_LOAD(pc_load), .PC_NEXT(pc_next), .REG_WE(reg_we),
    .REG_WDATA(reg_wdata), .IO_WE(io_we), .IO_WDATA(io_wdata), .STATUS_FLAGS(flags));

  // Core clock, 10 ns period
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Verdict and end of run
  task automatic conclude();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Issue one instruction, count clocks until the done pulse
  task automatic run(input logic [5:0] o, input logic [2:0] b, input logic [6:0] k,
                     input logic [15:0] p, input logic t, input logic [7:0] rd,
                     input logic [7:0] io);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    bsel <= b;
    ofs <= k;
    pc <= p;
    tw <= t;
    rdat <= rd;
    iodat <= io;
    @(posedge clk);
    start <= 1'b0;
    cyc = 1;
    #1;
    while (done !== 1'b1 && cyc < 6) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (done !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask

  // Length, strobes and status byte in the done cycle
  task automatic post(input int n, input logic pl, input logic rw, input logic iw);
    chk({cyc[3:0], pc_load, reg_we, io_we}, {n[3:0], pl, rw, iw});
    chk(flags, flg);
  endtask

  // Load the status byte one bit at a time
  task automatic setf(input logic [7:0] p);
    for (int i = 0; i < 8; i++) begin
      run(p[i] ? OP_SET_STATUS_FLAG_BIT : OP_CLEAR_STATUS_FLAG_BIT, i[2:0], 7'h00,
          16'h0000, 1'b0, 8'h00, 8'h00);
      flg[i] = p[i];
      post(1, 1'b0, 1'b0, 1'b0);
    end
  endtask

  // Whether a branch is taken for the given flags
  function automatic logic take(input logic [5:0] o, input logic [7:0] f,
                                input logic [2:0] b);
    case (o)
      OP_BRANCH_IF_FLAG_SET: return f[b];
      OP_BRANCH_IF_FLAG_CLEAR: return !f[b];
      OP_BRANCH_IF_EQUAL: return f[1];
      OP_BRANCH_IF_NOT_EQUAL: return !f[1];
      OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: return f[0];
      OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: return !f[0];
      OP_BRANCH_IF_MINUS: return f[2];
      OP_BRANCH_IF_PLUS: return !f[2];
      OP_BRANCH_IF_SIGNED_GE: return !(f[2] ^ f[3]);
      OP_BRANCH_IF_SIGNED_LESS: return f[2] ^ f[3];
      OP_BRANCH_IF_HALF_CARRY_SET: return f[5];
      OP_BRANCH_IF_HALF_CARRY_CLEAR: return !f[5];
      OP_BRANCH_IF_TRANSFER_FLAG_SET: return f[6];
      OP_BRANCH_IF_TRANSFER_FLAG_CLEAR: return !f[6];
      OP_BRANCH_IF_OVERFLOW_SET: return f[3];
      OP_BRANCH_IF_OVERFLOW_CLEAR: return !f[3];
      OP_BRANCH_IF_IRQ_ENABLED: return f[7];
      default: return !f[7];
    endcase
  endfunction

  // Main sequence
  initial begin
    logic [7:0] pats [4];
    logic [7:0] d [3];
    logic [7:0] r, v;
    logic [6:0] k;
    logic t, c;
    pats = '{8'h00, 8'hff, 8'h55, 8'haa};
    d = '{8'h81, 8'h01, 8'h80};
    rstn = 1'b0;
    start = 1'b0;
    op = '0;
    bsel = 3'h0;
    ofs = '0;
    pc = 16'h0000;
    tw = 1'b0;
    rdat = 8'h00;
    iodat = 8'h00;
    err_total = 0;
    checked = 0;
    flg = FLAGS_RESET;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({ready, done, flags}, {1'b1, 1'b0, FLAGS_RESET});
    // All branches against four flag patterns, both offset extremes
    foreach (pats[j]) begin
      setf(pats[j]);
      for (int i = 3; i <= 22; i++) begin
        for (int b = 0; b < (i < 5 ? 8 : 1); b++) begin
          k = (b[0] ^ j[0]) ? 7'h3f : 7'h40;
          t = take(i[5:0], flg, b[2:0]);
          run(i[5:0], b[2:0], k, 16'h1000, 1'b0, 8'h00, 8'h00);
          post(t ? 2 : 1, t, 1'b0, 1'b0);
          if (t) chk(pc_next, 16'(16'h1001 + {{9{k[6]}}, k}));
        end
      end
    end
    // Skips: bit value and next-word length in all four combinations
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 4; s++) begin
        v = s[0] ? (8'h01 << (i + s)) : ~(8'h01 << (i + s));
        t = (i == 1) ? !s[0] : s[0];
        run(i[5:0], 3'(i + s), 7'h00, 16'h2000, s[1], i == 0 ? v : ~v, i == 0 ? ~v : v);
        post(t ? (s[1] ? 3 : 2) : 1, t, 1'b0, 1'b0);
        if (t) chk(pc_next, s[1] ? 16'h2003 : 16'h2002);
      end
    end
    // Single I/O bit set and clear
    for (int b = 0; b < 8; b++) begin
      run(OP_SET_IO_BIT, b[2:0], 7'h00, 16'h0000, 1'b0, 8'h00, 8'h5a);
      post(2, 1'b0, 1'b0, 1'b1);
      chk(io_wdata, 8'h5a | (8'h01 << b));
      run(OP_CLEAR_IO_BIT, b[2:0], 7'h00, 16'h0000, 1'b0, 8'h00, 8'h5a);
      post(2, 1'b0, 1'b0, 1'b1);
      chk(io_wdata, 8'h5a & ~(8'h01 << b));
    end
    // Shifts and rotates with both carry inputs
    foreach (d[j]) begin
      for (int i = 25; i <= 29; i++) begin
        c = j[0] ^ i[0];
        run(c ? OP_SET_CARRY_FLAG : OP_CLEAR_CARRY_FLAG, 3'h0, 7'h00, 16'h0000, 1'b0,
            8'h00, 8'h00);
        flg[0] = c;
        post(1, 1'b0, 1'b0, 1'b0);
        case (i)
          25: {c, r} = {d[j], 1'b0};
          26: {r, c} = {1'b0, d[j]};
          27: {c, r} = {d[j], c};
          28: {r, c} = {c, d[j]};
          default: {r, c} = {d[j][7], d[j]};
        endcase
        run(i[5:0], 3'h0, 7'h00, 16'h0000, 1'b0, d[j], 8'h00);
        flg[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        post(1, 1'b0, 1'b1, 1'b0);
        chk(reg_wdata, r);
      end
    end
    run(OP_SET_NEGATIVE_FLAG, 3'h0, 7'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
    flg[2] = 1'b1;
    post(1, 1'b0, 1'b0, 1'b0);
    // Bit moves between a register and the transfer flag
    for (int b = 0; b < 8; b++) begin
      run(OP_STORE_BIT_TO_TRANSFER_FLAG, b[2:0], 7'h00, 16'h0000, 1'b0, 8'ha5, 8'h00);
      flg[6] = b[0] ~^ b[2];
      post(1, 1'b0, 1'b0, 1'b0);
      run(OP_LOAD_BIT_FROM_TRANSFER_FLAG, b[2:0], 7'h00, 16'h0000, 1'b0, 8'h0f, 8'h00);
      r = 8'h0f;
      r[b] = flg[6];
      post(1, 1'b0, 1'b1, 1'b0);
      chk(reg_wdata, r);
    end
    conclude();
  end
endmodule
